// ===== gbcd_decoder.sv
`default_nettype none
// ============================================================
// bus command decoder, instrument side
// ============================================================

// Summary of operation
// [RULE_01] attention bytes are commands, others are data
// [RULE_02] attention, clear, remote lines are inputs only
// [RULE_03] interface clear drops talk and listen
// [RULE_04] remote enable permits remote operation
// [RULE_05] end flag marks last data byte
// [RULE_06] drive service request while instrument asks
// [RULE_07] universal clear pulses device clear
// [RULE_08] local lockout locks the front panel
// [RULE_09] poll enable and disable set poll mode
// [RULE_10] addressed commands need own listen address
// [RULE_11] selective clear only while listen addressed
// [RULE_12] go to local ends remote, unlocks panel
// [RULE_13] group trigger pulses the trigger output
// [RULE_14] unlisten drops listen state
// [RULE_15] untalk drops talk state
// [RULE_16] listen 20-3F, talk 40-5F, low five address
// [RULE_17] secondary group bytes are ignored
// [RULE_18] eighth data line is ignored in commands
// [RULE_19] controller sends unlisten, address, command
// [RULE_20] data accepted only when listen addressed
// [RULE_21] primary address 0 to 30 from switches
// [RULE_22] switches read once after power-up reset
// [RULE_23] all bus lines are active low
// [RULE_24] three-wire interlocked byte handshake
// [RULE_25] own talk address sets talk, other clears
module gbcd_decoder
   import gbcd_pkg::*;
#(
   parameter logic [6:0] LOCKOUT_CODE = 7'h11,   // local lockout code
   parameter bit         TRIG_UNADDR  = 1'b0     // trigger without address
) (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   // bus pins, active low, controller-only lines are inputs
   input  wire logic [7:0] bus_dio_n,
   input  wire logic       bus_dav_n,
   input  wire logic       bus_atn_n,
   input  wire logic       bus_ifc_n,
   input  wire logic       bus_ren_n,
   input  wire logic       bus_eoi_n,
   // open-drain bus outputs, enable low while pulling
   output logic            bus_nrfd_out,
   output logic            bus_nrfd_oe_n,
   output logic            bus_ndac_out,
   output logic            bus_ndac_oe_n,
   output logic            bus_srq_out,
   output logic            bus_srq_oe_n,
   // address switches
   input  wire logic [4:0] addr_sw,
   // instrument requests
   input  wire logic       dd_ready,
   input  wire logic       svc_req,
   // received device data
   output logic [7:0]      dd_data,
   output logic            dd_valid,
   output logic            dd_end,
   // interface state
   output logic            listen,
   output logic            talk,
   output logic            remote,
   output logic            panel_lock,
   output logic            spoll_mode,
   output logic [4:0]      my_addr,
   output logic            addr_ok,
   // one-cycle events
   output logic            dev_clear,
   output logic            trigger
);

   // a lockout code outside the control group would also match an address or secondary byte
   if (LOCKOUT_CODE[6:5] != GBCD_GRP_CTL) begin : g_bad_llo
      $error("gbcd_decoder: LOCKOUT_CODE must lie below 7'h20");
   end

   // ============================================================
   // decode helpers
   // ============================================================

   // exact match of a seven-bit code
   function automatic logic cmd_is(input logic [6:0] c, input logic [6:0] k);
      return c == k;
   endfunction

   // address byte of the given group naming this device
   function automatic logic own_addr(input logic [6:0] c, input logic [1:0] g,
                                     input logic [4:0] a, input logic ok);
      return ok && c[6:5] == g && c[4:0] == a;   // RULE_17
   endfunction

   // ============================================================
   // pin synchronisers
   // ============================================================
   logic [17:0] pin_q;      // synchronised pins, raw polarity
   logic [7:0]  dio;        // data lines, active high
   logic        dav;        // data valid
   logic        atn;        // attention
   logic        ifc;        // interface clear
   logic        ren;        // remote enable
   logic        eoi;        // end or identify
   logic [4:0]  addr_now;   // switch setting, live

   gbcd_sync #(
      .WIDTH (18)
   ) u_sync (
      .core_clk (core_clk),
      .d        ({bus_dio_n, bus_dav_n, bus_atn_n, bus_ifc_n,
                  bus_ren_n, bus_eoi_n, addr_sw}),
      .q        (pin_q)
   );

   // low level on the wire means asserted
   assign dio      = ~pin_q[17:10];   // RULE_23
   assign dav      = ~pin_q[9];       // RULE_23
   assign atn      = ~pin_q[8];       // RULE_23
   assign ifc      = ~pin_q[7];       // RULE_23
   assign ren      = ~pin_q[6];       // RULE_23
   assign eoi      = ~pin_q[5];       // RULE_23
   assign addr_now = pin_q[4:0];

   // ============================================================
   // byte acceptor
   // ============================================================
   logic       nrfd_drv;   // pull nrfd
   logic       ndac_drv;   // pull ndac
   logic       rx_stb;     // one byte taken
   logic [7:0] rx_data;    // byte taken
   logic       rx_atn;     // byte came under attention
   logic       rx_eoi;     // byte came with end flag

   // commands always accepted; data only while listening
   gbcd_hshk u_hshk (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .active   (atn || listen),     // RULE_20
      .ready    (atn || dd_ready),
      .dav      (dav),
      .atn      (atn),
      .eoi      (eoi),
      .dio      (dio),
      .nrfd_drv (nrfd_drv),
      .ndac_drv (ndac_drv),
      .rx_stb   (rx_stb),
      .rx_data  (rx_data),
      .rx_atn   (rx_atn),
      .rx_eoi   (rx_eoi)
   );

   // open-drain: output value fixed low, enable carries the level
   assign bus_nrfd_out  = 1'b0;
   assign bus_nrfd_oe_n = ~nrfd_drv;
   assign bus_ndac_out  = 1'b0;
   assign bus_ndac_oe_n = ~ndac_drv;
   assign bus_srq_out   = 1'b0;

   // ============================================================
   // command classification
   // ============================================================
   logic [6:0] cmd;        // seven-bit command code
   logic       cmd_stb;    // command byte taken
   logic       data_stb;   // data byte taken

   assign cmd      = rx_data[6:0];        // RULE_18
   assign cmd_stb  = rx_stb && rx_atn;    // RULE_01
   assign data_stb = rx_stb && !rx_atn;   // RULE_01

   // ============================================================
   // primary address, caught once after reset release
   // ============================================================
   logic addr_taken;   // switches already read

   // later switch moves are ignored until the next power-up
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         addr_taken <= 1'b0;
         my_addr    <= GBCD_ADDR_NONE;
      end else if (!addr_taken) begin
         addr_taken <= 1'b1;       // RULE_22
         my_addr    <= addr_now;   // RULE_22
      end
   end

   // the all-ones setting is not a device address
   assign addr_ok = addr_taken && my_addr != GBCD_ADDR_NONE;   // RULE_21

   // ============================================================
   // listener and talker state
   // ============================================================

   // listen: own address sets, unlisten clears, others leave it
   always_ff @(posedge core_clk) begin
      if (sys_rst || ifc) begin
         listen <= GBCD_RST_LISTEN;   // RULE_03
      end else if (cmd_stb) begin
         if (cmd_is(cmd, GBCD_CMD_UNL)) begin
            listen <= 1'b0;           // RULE_14
         end else if (own_addr(cmd, GBCD_GRP_LAG, my_addr, addr_ok)) begin
            listen <= 1'b1;           // RULE_16
         end
      end
   end

   // talk: only one talker, so any other talk address clears
   always_ff @(posedge core_clk) begin
      if (sys_rst || ifc) begin
         talk <= GBCD_RST_TALK;       // RULE_03
      end else if (cmd_stb) begin
         if (cmd_is(cmd, GBCD_CMD_UNT)) begin
            talk <= 1'b0;             // RULE_15
         end else if (cmd[6:5] == GBCD_GRP_TAG) begin
            talk <= own_addr(cmd, GBCD_GRP_TAG, my_addr, addr_ok);   // RULE_25
         end
      end
   end

   // ============================================================
   // serial poll, remote and lockout
   // ============================================================

   // poll mode is universal; no address needed
   always_ff @(posedge core_clk) begin
      if (sys_rst || ifc) begin
         spoll_mode <= GBCD_RST_SPOLL;
      end else if (cmd_stb && cmd_is(cmd, GBCD_CMD_SPE)) begin
         spoll_mode <= 1'b1;          // RULE_09
      end else if (cmd_stb && cmd_is(cmd, GBCD_CMD_SPD)) begin
         spoll_mode <= 1'b0;          // RULE_09
      end
   end

   // remote entered by own listen address under remote enable
   always_ff @(posedge core_clk) begin
      if (sys_rst || !ren) begin
         remote <= GBCD_RST_REMOTE;   // RULE_04
      end else if (cmd_stb && listen && cmd_is(cmd, GBCD_CMD_GTL)) begin
         remote <= 1'b0;              // RULE_12
      end else if (cmd_stb && own_addr(cmd, GBCD_GRP_LAG, my_addr, addr_ok)) begin
         remote <= 1'b1;              // RULE_04
      end
   end

   // lockout survives unlisten but not go-to-local
   always_ff @(posedge core_clk) begin
      if (sys_rst || !ren) begin
         panel_lock <= GBCD_RST_LOCK;
      end else if (cmd_stb && listen && cmd_is(cmd, GBCD_CMD_GTL)) begin
         panel_lock <= 1'b0;          // RULE_12
      end else if (cmd_stb && cmd_is(cmd, LOCKOUT_CODE)) begin
         panel_lock <= 1'b1;          // RULE_08
      end
   end

   // ============================================================
   // clear and trigger events
   // ============================================================

   // secondary group bytes fall through every branch: ignored
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         dev_clear <= 1'b0;
         trigger   <= 1'b0;
      end else begin
         dev_clear <= cmd_stb && (cmd_is(cmd, GBCD_CMD_DCL)              // RULE_07
                      || (listen && cmd_is(cmd, GBCD_CMD_SDC)));         // RULE_11 RULE_10
         trigger   <= cmd_stb && cmd_is(cmd, GBCD_CMD_GET)
                      && (listen || TRIG_UNADDR);                        // RULE_13 RULE_10
      end
   end

   // ============================================================
   // device data path and service request
   // ============================================================

   // data bytes pass one per handshake with their end flag
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         dd_valid <= 1'b0;
         dd_data  <= 8'h00;
         dd_end   <= 1'b0;
      end else begin
         dd_valid <= data_stb && listen;   // RULE_20
         if (data_stb && listen) begin
            dd_data <= rx_data;
            dd_end  <= rx_eoi;             // RULE_05
         end
      end
   end

   // service request line follows the instrument's request
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         bus_srq_oe_n <= 1'b1;
      end else begin
         bus_srq_oe_n <= ~svc_req;   // RULE_06
      end
   end

   // ============================================================
   // checks
   // ============================================================
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence s_cmd(logic [6:0] k);
      cmd_stb && !ifc && cmd == k;
   endsequence

   property p_unl;
      s_cmd(GBCD_CMD_UNL) |=> !listen;
   endproperty
   a_unl: assert property (p_unl)   // RULE_14
      else $error("unlisten left device listening");

   property p_unt;
      s_cmd(GBCD_CMD_UNT) |=> !talk;
   endproperty
   a_unt: assert property (p_unt)   // RULE_15
      else $error("untalk left device talking");

   property p_mla;
      cmd_stb && !ifc && addr_ok && cmd == {GBCD_GRP_LAG, my_addr} |=> listen;
   endproperty
   a_mla: assert property (p_mla)   // RULE_16
      else $error("own listen address not taken");

   property p_tag_other;
      cmd_stb && !ifc && cmd[6:5] == GBCD_GRP_TAG && cmd[4:0] != my_addr |=> !talk;
   endproperty
   a_tag_other: assert property (p_tag_other)   // RULE_25
      else $error("foreign talk address kept talk state");

   property p_ifc;
      ifc |=> !listen && !talk;
   endproperty
   a_ifc: assert property (p_ifc)   // RULE_03
      else $error("interface clear did not idle the device");

   property p_dcl;
      s_cmd(GBCD_CMD_DCL) |=> dev_clear ##1 !dev_clear;
   endproperty
   a_dcl: assert property (p_dcl)   // RULE_07
      else $error("device clear pulse wrong");

   property p_sdc_unaddr;
      s_cmd(GBCD_CMD_SDC) and !listen |=> !dev_clear;
   endproperty
   a_sdc_unaddr: assert property (p_sdc_unaddr)   // RULE_11
      else $error("selective clear acted unaddressed");

   property p_spoll;
      s_cmd(GBCD_CMD_SPE) |=> spoll_mode;
   endproperty
   a_spoll: assert property (p_spoll)   // RULE_09
      else $error("poll enable ignored");

   property p_gtl;
      s_cmd(GBCD_CMD_GTL) and listen |=> !remote && !panel_lock;
   endproperty
   a_gtl: assert property (p_gtl)   // RULE_12
      else $error("go to local ignored");

   property p_data;
      data_stb && listen |=> dd_valid && dd_data == $past(rx_data);
   endproperty
   a_data: assert property (p_data)   // RULE_20
      else $error("data byte not delivered");

   property p_cmd_not_data;
      cmd_stb |=> !dd_valid;
   endproperty
   a_cmd_not_data: assert property (p_cmd_not_data)   // RULE_01
      else $error("command byte passed as data");

   property p_scg;
      cmd_stb && !ifc && cmd[6:5] == GBCD_GRP_SCG |=> $stable(listen) && $stable(talk);
   endproperty
   a_scg: assert property (p_scg)   // RULE_17
      else $error("secondary byte changed addressing");

endmodule
`default_nettype wire

// ===== gbcd_pkg.sv
`default_nettype none
// ============================================================
// shared constants for the bus command decoder
// ============================================================
package gbcd_pkg;

   // widths of the bus byte, command code and primary address
   localparam int GBCD_BYTE_W = 8;
   localparam int GBCD_CMD_W  = 7;
   localparam int GBCD_ADDR_W = 5;

   // ============================================================
   // command codes, seven bits, top data line ignored
   // ============================================================
   localparam logic [6:0] GBCD_CMD_GTL = 7'h01;   // go to local
   localparam logic [6:0] GBCD_CMD_SDC = 7'h04;   // selective clear
   localparam logic [6:0] GBCD_CMD_GET = 7'h08;   // group trigger
   localparam logic [6:0] GBCD_CMD_DCL = 7'h14;   // universal clear
   localparam logic [6:0] GBCD_CMD_SPE = 7'h18;   // serial poll on
   localparam logic [6:0] GBCD_CMD_SPD = 7'h19;   // serial poll off
   localparam logic [6:0] GBCD_CMD_UNL = 7'h3F;   // unlisten
   localparam logic [6:0] GBCD_CMD_UNT = 7'h5F;   // untalk

   // ============================================================
   // command groups, held in code bits 6:5
   // ============================================================
   localparam logic [1:0] GBCD_GRP_CTL = 2'h0;    // addressed and universal
   localparam logic [1:0] GBCD_GRP_LAG = 2'h1;    // listen addresses
   localparam logic [1:0] GBCD_GRP_TAG = 2'h2;    // talk addresses
   localparam logic [1:0] GBCD_GRP_SCG = 2'h3;    // secondary, ignored

   // address value that no device may own
   localparam logic [4:0] GBCD_ADDR_NONE = 5'h1F;

   // ============================================================
   // reset values of the interface state
   // ============================================================
   localparam logic GBCD_RST_LISTEN = 1'b0;
   localparam logic GBCD_RST_TALK   = 1'b0;
   localparam logic GBCD_RST_REMOTE = 1'b0;
   localparam logic GBCD_RST_LOCK   = 1'b0;
   localparam logic GBCD_RST_SPOLL  = 1'b0;

   // acceptor handshake states
   typedef enum logic {GBCD_HS_RDY, GBCD_HS_ACPT} gbcd_hs_t;

endpackage
`default_nettype wire

// ===== gbcd_sync.sv
`default_nettype none
// ============================================================
// two flip-flop synchroniser for pin inputs
// ============================================================
module gbcd_sync
   import gbcd_pkg::*;
#(
   parameter int WIDTH = 1
) (
   // clock
   input  wire logic             core_clk,
   // asynchronous inputs and their synchronised copies
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);

   // refuse an empty vector
   if (WIDTH < 1) begin : g_bad_width
      $error("gbcd_sync: WIDTH must be at least one");
   end

   logic [WIDTH-1:0] meta;   // first stage, read only by the second

   // no reset: the chain flushes while sys_rst is held
   always_ff @(posedge core_clk) begin
      meta <= d;
      q    <= meta;
   end

endmodule
`default_nettype wire

// ===== gbcd_hshk.sv
`default_nettype none
// ============================================================
// three-wire acceptor handshake, one strobe per byte
// ============================================================
module gbcd_hshk
   import gbcd_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   // synchronised bus inputs, active high here
   input  wire logic       active,
   input  wire logic       ready,
   input  wire logic       dav,
   input  wire logic       atn,
   input  wire logic       eoi,
   input  wire logic [7:0] dio,
   // line drives, high means pull the line low
   output logic            nrfd_drv,
   output logic            ndac_drv,
   // captured byte
   output logic            rx_stb,
   output logic [7:0]      rx_data,
   output logic            rx_atn,
   output logic            rx_eoi
);

   gbcd_hs_t state;   // acceptor position in the interlock

   // state walk; leaving the bus releases both lines at once
   always_ff @(posedge core_clk) begin
      if (sys_rst || !active) begin
         state <= GBCD_HS_RDY;
      end else begin
         unique case (state)
            GBCD_HS_RDY: begin
               // a byte is only taken once we let nrfd go
               if (dav && ready) begin
                  state <= GBCD_HS_ACPT;
               end
            end
            GBCD_HS_ACPT: begin
               // wait for the source to drop data valid
               if (!dav) begin
                  state <= GBCD_HS_RDY;
               end
            end
         endcase
      end
   end

   // byte capture, data and flags taken in the same edge
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rx_stb  <= 1'b0;
         rx_data <= 8'h00;
         rx_atn  <= 1'b0;
         rx_eoi  <= 1'b0;
      end else begin
         rx_stb <= active && state == GBCD_HS_RDY && dav && ready;   // RULE_24
         if (active && state == GBCD_HS_RDY && dav && ready) begin
            rx_data <= dio;
            rx_atn  <= atn;
            rx_eoi  <= eoi;
         end
      end
   end

   // nrfd held while busy or not ready, ndac held until accepted
   assign nrfd_drv = active && (state == GBCD_HS_ACPT || !ready);   // RULE_24
   assign ndac_drv = active && state == GBCD_HS_RDY;                // RULE_24

   // ============================================================
   // checks
   // ============================================================
   sequence s_taken;
      rx_stb;
   endsequence

   property p_hs_accept;
      @(posedge core_clk) disable iff (sys_rst)
      s_taken and active |-> !ndac_drv && nrfd_drv;
   endproperty
   a_hs_accept: assert property (p_hs_accept)   // RULE_24
      else $error("ndac not released after byte taken");

   property p_hs_single;
      @(posedge core_clk) disable iff (sys_rst)
      s_taken |=> !rx_stb;
   endproperty
   a_hs_single: assert property (p_hs_single)   // RULE_24
      else $error("two strobes for one byte");

endmodule
`default_nettype wire

// ===== gbcd_ctl_model.sv
`default_nettype none
// ============================================================
// behavioural bus controller, source side of each byte
// ============================================================
module gbcd_ctl_model (
   // clock
   input  wire logic       core_clk,
   // handshake wire levels, low means asserted
   input  wire logic       nrfd_n,
   input  wire logic       ndac_n,
   // source lines, active low
   output var  logic [7:0] bus_dio_n,
   output var  logic       bus_dav_n,
   output var  logic       bus_atn_n,
   output var  logic       bus_eoi_n,
   // a wait ran out, the bus is stuck
   output var  logic       hung
);
   timeunit 1ns;
   timeprecision 1ps;

   // released lines sit at the terminator level, high
   initial begin
      bus_dio_n <= 8'hFF;
      bus_dav_n <= 1'b1;
      bus_atn_n <= 1'b1;
      bus_eoi_n <= 1'b1;
      hung      <= 1'b0;
   end

   // one byte; data settles three cycles before valid is raised, so
   // the acceptor's nrfd already answers the new attention level
   task automatic send(input logic atn, input logic [7:0] b, input logic eoi);
      int n;
      n = 0;
      @(posedge core_clk);
      bus_dio_n <= ~b;
      bus_atn_n <= ~atn;
      bus_eoi_n <= ~eoi;
      repeat (3) @(posedge core_clk);
      // wait for every acceptor ready, bounded
      while (nrfd_n !== 1'b1 && n < 400) begin
         n++;
         @(posedge core_clk);
      end
      bus_dav_n <= 1'b0;
      @(posedge core_clk);
      while (ndac_n !== 1'b1 && n < 800) begin
         n++;
         @(posedge core_clk);
      end
      if (n >= 400) begin
         hung <= 1'b1;
      end
      bus_dav_n <= 1'b1;
      bus_dio_n <= 8'hFF;
      bus_eoi_n <= 1'b1;
      repeat (4) @(posedge core_clk);
   endtask
endmodule
`default_nettype wire

// ===== testbench.sv
`default_nettype none
// ============================================================
// self-checking bench for the bus command decoder
// ============================================================
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import gbcd_pkg::*;
   localparam logic [6:0] LLO_C = 7'h11;  // lockout code under test
   logic core_clk, sys_rst, dd_ready, svc_req, bus_ifc_n, bus_ren_n, hung;
   logic [7:0] bus_dio_n, dd_data;
   logic [4:0] addr_sw, my_addr;
   logic bus_dav_n, bus_atn_n, bus_eoi_n, bus_nrfd_out, bus_nrfd_oe_n;
   logic bus_ndac_out, bus_ndac_oe_n, bus_srq_out, bus_srq_oe_n, dd_valid;
   logic dd_end, listen, talk, remote, panel_lock, spoll_mode, addr_ok;
   logic dev_clear, trigger;
   logic [11:0] exq[$];  // expected {valid,clear,trig,end,data}
   int failures = 0;
   int n_checks = 0;
   // wire levels: pulled low while an enable is low
   wire logic nrfd_n = bus_nrfd_oe_n | bus_nrfd_out;
   wire logic ndac_n = bus_ndac_oe_n | bus_ndac_out;

   gbcd_decoder #(.LOCKOUT_CODE(LLO_C), .TRIG_UNADDR(1'b0)) gbcd_decoder_i (
      .core_clk, .sys_rst, .bus_dio_n, .bus_dav_n, .bus_atn_n, .bus_ifc_n,
      .bus_ren_n, .bus_eoi_n, .bus_nrfd_out, .bus_nrfd_oe_n, .bus_ndac_out,
      .bus_ndac_oe_n, .bus_srq_out, .bus_srq_oe_n, .addr_sw, .dd_ready,
      .svc_req, .dd_data, .dd_valid, .dd_end, .listen, .talk, .remote,
      .panel_lock, .spoll_mode, .my_addr, .addr_ok, .dev_clear, .trigger);
   gbcd_ctl_model gbcd_ctl_model_i (.core_clk, .nrfd_n, .ndac_n, .bus_dio_n,
      .bus_dav_n, .bus_atn_n, .bus_eoi_n, .hung);

   // ============================================================
   // clock, compare, verdict
   // ============================================================
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      if (failures == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // an empty queue turns any stray pulse into a mismatch
   always @(posedge core_clk) begin
      if (dd_valid === 1'b1 || dev_clear === 1'b1 || trigger === 1'b1)
         chk(dd_valid ? {3'b100, dd_end, dd_data} : {1'b0, dev_clear, trigger, 9'h0},
             exq.size() ? exq.pop_front() : 12'h000);
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      end_of_test();
   end

   // ============================================================
   // stimulus helpers; command bit 7 is random
   // ============================================================
   task automatic cmd(input logic [6:0] c);
      gbcd_ctl_model_i.send(1'b1, {1'($urandom_range(1, 0)), c}, 1'b0);
      repeat (4) @(posedge core_clk);
   endtask
   task automatic dat(input logic [7:0] d, input logic e, input logic seen);
      if (seen) exq.push_back({3'b100, e, d});
      gbcd_ctl_model_i.send(1'b0, d, e);
   endtask
   task automatic ev(input logic [1:0] x);
      exq.push_back({1'b0, x, 9'h0});
   endtask
   task automatic st(input logic [4:0] x);
      chk({7'h0, listen, talk, remote, panel_lock, spoll_mode}, {7'h0, x});
   endtask

   initial begin
      logic [4:0] a, o;
      void'($urandom(32'hB4935206));
      a = 5'($urandom_range(30, 0));
      o = (a == 5'd30) ? 5'd0 : a + 5'd1;
      sys_rst <= 1'b1;
      dd_ready <= 1'b1;
      svc_req <= 1'b0;
      addr_sw <= a;
      bus_ifc_n <= 1'b1;
      bus_ren_n <= 1'b0;
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      addr_sw <= ~a;            // moved after power-up, must be ignored
      repeat (3) @(posedge core_clk);
      chk({6'h0, addr_ok, my_addr}, {6'h1, a});
      cmd(GBCD_CMD_UNL);
      cmd({2'h1, a});
      st(5'b10100);
      dd_ready <= 1'b0;
      fork
         begin
            repeat (25) @(posedge core_clk);
            chk({11'h0, bus_nrfd_oe_n}, 12'h000);
            dd_ready <= 1'b1;
         end
         for (int i = 0; i < 3; i++) dat(8'($urandom), i == 2, 1'b1);
      join
      ev(2'b10); cmd(GBCD_CMD_SDC);
      ev(2'b01); cmd(GBCD_CMD_GET);
      ev(2'b10); cmd(GBCD_CMD_DCL);
      cmd(GBCD_CMD_SPE); st(5'b10101);
      cmd(GBCD_CMD_SPD); cmd(LLO_C); st(5'b10110);
      cmd(GBCD_CMD_GTL); st(5'b10000);
      cmd({2'h2, a}); cmd({2'h3, a}); st(5'b11000);
      cmd({2'h2, o}); st(5'b10000);
      cmd({2'h2, a}); cmd(GBCD_CMD_UNT); st(5'b10000);
      cmd(GBCD_CMD_UNL); st(5'b00000);
      cmd(GBCD_CMD_SDC); cmd(GBCD_CMD_GET); dat(8'h5A, 1'b0, 1'b0);
      cmd({2'h1, a}); cmd({2'h2, a}); cmd(GBCD_CMD_SPE); st(5'b11101);
      bus_ifc_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      bus_ifc_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      st(5'b00100);
      bus_ren_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      st(5'b00000);
      svc_req <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk({8'h0, bus_srq_oe_n, bus_nrfd_out, bus_ndac_out, bus_srq_out}, 12'h000);
      svc_req <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk({10'h0, bus_srq_oe_n, hung}, 12'h002);
      chk(12'(exq.size()), 12'h000);
      end_of_test();
   end
endmodule
`default_nettype wire
